// File: src/iss_pkg.sv
/*
  Constants of the image signature inserter: register map, field
  positions, reset values and timing figures.
  Assumes a 125 MHz system clock and 32-bit AXI4-Lite access.
*/
package iss_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] ISS_A_BIN_CTL = 32'hf10005b0;
  localparam logic [31:0] ISS_A_FRM_CTL = 32'hf1000610;
  localparam logic [31:0] ISS_A_FRM_VAL = 32'hf1000614;
  localparam logic [31:0] ISS_A_TRG_CTL = 32'hf1000620;
  localparam logic [31:0] ISS_A_TRG_VAL = 32'hf1000624;
  localparam logic [31:0] ISS_A_SIG_CTL = 32'hf1000630;
  localparam logic [31:0] ISS_A_SIG_USR = 32'hf1000634;
  // ==========================================================
  // Field positions, quadlet position [n] is bit 31-n
  localparam int ISS_B_PRES  = 31;
  localparam int ISS_B_RST   = 30;
  localparam int ISS_B_ONOFF = 25;
  localparam int ISS_LINE_HI = 15;
  // ==========================================================
  // Reset values
  localparam logic [15:0] ISS_LINE_RST = 16'h0000;
  localparam logic [31:0] ISS_CNT_RST  = 32'h00000000;
  localparam logic [31:0] ISS_USR_RST  = 32'h00000000;
  // ==========================================================
  // Record layout and sequence store
  localparam logic [5:0] ISS_REC_LEN = 6'h30;
  localparam logic [3:0] ISS_W_CT    = 4'h0;
  localparam logic [3:0] ISS_W_FC    = 4'h1;
  localparam logic [3:0] ISS_W_TC    = 4'h2;
  localparam logic [3:0] ISS_W_USR   = 4'hb;
  localparam int         ISS_SEQ_N   = 16;
  // ==========================================================
  // Cycle time structure
  localparam logic [11:0] ISS_OFF_MAX = 12'hbff;
  localparam logic [12:0] ISS_CYC_MAX = 13'h1f3f;
  localparam longint ISS_CLK_HZ  = 125000000;
  localparam longint ISS_OFF_HZ  = 24576000;
  localparam logic [16:0] ISS_PH_MOD =
    17'(ISS_CLK_HZ / 1000);
  localparam logic [16:0] ISS_PH_INC =
    17'(ISS_OFF_HZ / 1000);
  // ==========================================================
  // Bus responses
  localparam logic [1:0] ISS_OKAY   = 2'h0;
  localparam logic [1:0] ISS_SLVERR = 2'h2;
endpackage

// File: src/iss_top.sv
/*
  Image signature inserter: AXI4-Lite registers, frame and trigger
  counters, bus cycle time, record insertion into a byte stream and
  low noise binning averaging.
  Assumes inputs synchronous to clk; stream bytes of a frame arrive
  while sensor_readout_window is high, starting one cycle after its
  rise; line ends are flagged on the last byte of each line.
*/
// Notes on behaviour
// R1: Low noise binning averages instead of summing
// R2: Presence bit reads one, ignores writes
// R3: Enabled signature goes into every image whose position lies in range
// R4: Insert line taken from low 16 bits
// R5: Non-negative position counts from top
// R6: Negative position counts from bottom
// R7: Position equal height uses padding line
// R8: No padding means record is omitted
// R9: User word per sequence entry inserted
// R10: Cycle time sampled at integration start
// R11: Cycle time in bytes 1-4, LSB first
// R12: Cycle time is offset, cycles, seconds
// R13: Seconds top, cycles middle, offset low
// R14: Frame tally counts each readout window
// R15: Frame tally in bytes 5 to 8
// R16: Reset bit clears counter, self clears
// R17: Frame tally readable live
// R18: Trigger tally counts triggers, readable
// R19: Trigger tally in bytes 9 to 12
// R20: One enable and position for all
// R21: Record 48 bytes, user word last
// R22: Position [0] is the top bit
// R23: Tallies wrap to zero
// R24: Reserved bits read zero
`timescale 1ns/1ns
`default_nettype none
module iss_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Sensor events
  input  wire logic        sensor_readout_window,
  input  wire logic        integ_start,
  input  wire logic        ext_trigger,
  input  wire logic        seq_mode,
  input  wire logic [3:0]  seq_index,
  // Frame geometry
  input  wire logic [15:0] image_line_total,
  input  wire logic        pad_present,
  // Pixel byte stream in
  input  wire logic        pix_valid,
  input  wire logic [7:0]  pix_data,
  input  wire logic        pix_line_end,
  // Pixel byte stream out
  output logic             out_valid,
  output logic [7:0]       out_data,
  output logic             out_line_end,
  // Binning datapath
  input  wire logic        bin_valid,
  input  wire logic [15:0] bin_sum,
  input  wire logic        bin_x4,
  output logic             bin_out_valid,
  output logic [15:0]      bin_out
);
  import iss_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Bus handshakes
  logic        awrdy_q, wrdy_q, bvalid_q, arrdy_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] fc_q, tc_q;
  wire         wr_map;
  wire wr_go = awrdy_q & s_axi_awvalid & s_axi_wvalid;
  wire rd_go = arrdy_q & s_axi_arvalid;
  wire wr_req = s_axi_awvalid & s_axi_wvalid & ~awrdy_q
              & ~bvalid_q;
  wire rd_req = s_axi_arvalid & ~arrdy_q & ~rvalid_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awrdy_q  <= 1'b0;
      wrdy_q   <= 1'b0;
      arrdy_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= ISS_OKAY;
    end else begin
      awrdy_q <= wr_req;
      wrdy_q  <= wr_req;
      arrdy_q <= rd_req;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? ISS_OKAY : ISS_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Write decode
  wire [31:0] wa = s_axi_awaddr;
  wire [31:0] wd = s_axi_wdata;
  wire [3:0]  ws = s_axi_wstrb;
  assign wr_map = wa == ISS_A_BIN_CTL || wa == ISS_A_FRM_CTL
             || wa == ISS_A_FRM_VAL || wa == ISS_A_TRG_CTL
             || wa == ISS_A_TRG_VAL || wa == ISS_A_SIG_CTL
             || wa == ISS_A_SIG_USR;
  wire w_bin = wr_go & (wa == ISS_A_BIN_CTL);
  wire w_sig = wr_go & (wa == ISS_A_SIG_CTL);
  wire w_usr = wr_go & (wa == ISS_A_SIG_USR);
  wire fc_rst = wr_go & (wa == ISS_A_FRM_CTL) & ws[3]
              & wd[ISS_B_RST];
  wire tc_rst = wr_go & (wa == ISS_A_TRG_CTL) & ws[3]
              & wd[ISS_B_RST];

  // ==========================================================
  // Control registers
  logic        bin_en_q, sig_en_q;
  logic [15:0] line_q;
  logic [31:0] usr_q [ISS_SEQ_N];
  wire  [3:0]  seq_sel = seq_mode ? seq_index : 4'h0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bin_en_q <= 1'b0;
      sig_en_q <= 1'b0;
      line_q   <= ISS_LINE_RST;
    end else begin
      if (w_bin && ws[3])
        bin_en_q <= wd[ISS_B_ONOFF];
      if (w_sig && ws[3])
        sig_en_q <= wd[ISS_B_ONOFF];
      if (w_sig && ws[1])
        line_q[15:8] <= wd[15:8]; // R4
      if (w_sig && ws[0])
        line_q[7:0] <= wd[7:0]; // R4
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < ISS_SEQ_N; i++)
        usr_q[i] <= ISS_USR_RST;
    end else begin
      for (int b = 0; b < 4; b++)
        if (w_usr && ws[b])
          usr_q[seq_sel][b*8 +: 8] <= wd[b*8 +: 8]; // R9
    end
  end

  // ==========================================================
  // Read decode
  wire [31:0] ra = s_axi_araddr;
  wire [31:0] pres = 32'h1 << ISS_B_PRES;
  wire [31:0] onb  = 32'h1 << ISS_B_ONOFF;
  wire [31:0] r_bin = pres | (bin_en_q ? onb : 32'h0);
  wire [31:0] r_sig = pres | (sig_en_q ? onb : 32'h0)
                    | {16'h0, line_q};
  wire rd_map = ra == ISS_A_BIN_CTL || ra == ISS_A_FRM_CTL
             || ra == ISS_A_FRM_VAL || ra == ISS_A_TRG_CTL
             || ra == ISS_A_TRG_VAL || ra == ISS_A_SIG_CTL
             || ra == ISS_A_SIG_USR;
  wire [31:0] rd_val =
      ra == ISS_A_BIN_CTL ? r_bin : // R2 R22 R24
      ra == ISS_A_FRM_CTL ? pres :  // R16
      ra == ISS_A_FRM_VAL ? fc_q :  // R17
      ra == ISS_A_TRG_CTL ? pres :
      ra == ISS_A_TRG_VAL ? tc_q :  // R18
      ra == ISS_A_SIG_CTL ? r_sig :
      ra == ISS_A_SIG_USR ? usr_q[seq_sel] : 32'h0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= ISS_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_map ? ISS_OKAY : ISS_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Frame and trigger tallies
  logic        win_q, trg_q;
  wire win_rise = sensor_readout_window & ~win_q;
  wire trg_rise = ext_trigger & ~trg_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fc_q  <= ISS_CNT_RST;
      tc_q  <= ISS_CNT_RST;
      win_q <= 1'b0;
      trg_q <= 1'b0;
    end else begin
      win_q <= sensor_readout_window;
      trg_q <= ext_trigger;
      if (fc_rst)
        fc_q <= ISS_CNT_RST; // R16
      else if (win_rise)
        fc_q <= fc_q + 32'h1; // R14 R23
      if (tc_rst)
        tc_q <= ISS_CNT_RST; // R16
      else if (trg_rise)
        tc_q <= tc_q + 32'h1; // R18 R23
    end
  end

  // ==========================================================
  // Bus cycle time
  logic [16:0] ph_q;
  logic [11:0] off_q;
  logic [12:0] cyc_q;
  logic [6:0]  sec_q;
  logic [31:0] ct_q;
  wire [17:0] ph_sum = {1'b0, ph_q} + {1'b0, ISS_PH_INC};
  wire        ph_tick = ph_sum >= {1'b0, ISS_PH_MOD};
  wire [31:0] ct_word = {sec_q, cyc_q, off_q}; // R13

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_q  <= 17'h0;
      off_q <= 12'h0;
      cyc_q <= 13'h0;
      sec_q <= 7'h0;
      ct_q  <= 32'h0;
    end else begin
      ph_q <= ph_tick ? 17'(ph_sum - {1'b0, ISS_PH_MOD})
                      : ph_sum[16:0];
      if (ph_tick) begin
        if (off_q == ISS_OFF_MAX) begin // R12
          off_q <= 12'h0;
          if (cyc_q == ISS_CYC_MAX) begin
            cyc_q <= 13'h0;
            sec_q <= sec_q + 7'h1;
          end else begin
            cyc_q <= cyc_q + 13'h1;
          end
        end else begin
          off_q <= off_q + 12'h1;
        end
      end
      if (integ_start)
        ct_q <= ct_word; // R10
    end
  end

  // ==========================================================
  // Target line, latched per frame
  wire [15:0] ht = image_line_total;
  wire [16:0] neg_sum = {1'b0, ht} + {line_q[15], line_q};
  wire        pos_ok = line_q < ht
                     || (line_q == ht && pad_present); // R7 R8
  wire        tgt_ok = line_q[15] ? ~neg_sum[16] : pos_ok;
  wire [15:0] tgt = line_q[15] ? neg_sum[15:0] // R6
                                : line_q;      // R5
  logic        en_f_q, ok_f_q;
  logic [15:0] tgt_q, lc_q;
  logic [5:0]  bc_q;
  logic [31:0] rfc_q, rtc_q, rusr_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_f_q <= 1'b0;
      ok_f_q <= 1'b0;
      tgt_q  <= 16'h0;
      rfc_q  <= 32'h0;
      rtc_q  <= 32'h0;
      rusr_q <= 32'h0;
    end else if (win_rise) begin
      en_f_q <= sig_en_q; // R3 R20
      ok_f_q <= tgt_ok;
      tgt_q  <= tgt;
      rfc_q  <= fc_q;
      rtc_q  <= tc_q;
      rusr_q <= usr_q[seq_sel]; // R9
    end
  end

  // ==========================================================
  // Line and byte position
  wire bc_live = bc_q < ISS_REC_LEN;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lc_q <= 16'h0;
      bc_q <= 6'h0;
    end else if (win_rise) begin
      lc_q <= 16'h0;
      bc_q <= 6'h0;
    end else if (pix_valid) begin
      if (pix_line_end) begin
        lc_q <= lc_q + 16'h1;
        bc_q <= 6'h0;
      end else if (bc_live) begin
        bc_q <= bc_q + 6'h1;
      end
    end
  end

  // ==========================================================
  // Record byte selection and insertion
  wire [3:0]  wsel = bc_q[5:2];
  wire [31:0] rec_w =
      wsel == ISS_W_CT  ? ct_q  :  // R11
      wsel == ISS_W_FC  ? rfc_q :  // R15
      wsel == ISS_W_TC  ? rtc_q :  // R19
      wsel == ISS_W_USR ? rusr_q : // R21
      32'h0;
  wire [7:0] rec_b = rec_w[bc_q[1:0]*8 +: 8];
  wire ins = en_f_q & ok_f_q & (lc_q == tgt_q) & bc_live
           & pix_valid; // R3 R20

  logic       ov_q, ole_q;
  logic [7:0] od_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ov_q  <= 1'b0;
      ole_q <= 1'b0;
      od_q  <= 8'h0;
    end else begin
      ov_q  <= pix_valid;
      ole_q <= pix_valid & pix_line_end;
      od_q  <= ins ? rec_b : pix_data;
    end
  end

  // ==========================================================
  // Low noise binning
  logic        bv_q;
  logic [15:0] bo_q;
  wire  [15:0] avg = bin_x4 ? bin_sum >> 2 : bin_sum >> 1;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bv_q <= 1'b0;
      bo_q <= 16'h0;
    end else begin
      bv_q <= bin_valid;
      if (bin_valid)
        bo_q <= bin_en_q ? avg : bin_sum; // R1
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign out_valid     = ov_q;
  assign out_data      = od_q;
  assign out_line_end  = ole_q;
  assign bin_out_valid = bv_q;
  assign bin_out       = bo_q;

  // ==========================================================
  // Assertions
  property p_bin;
    bin_valid && bin_en_q |=>
      bo_q == ($past(bin_x4) ? $past(bin_sum) >> 2
                             : $past(bin_sum) >> 1);
  endproperty
  a_bin: assert property (p_bin) else $error("bin avg"); // R1

  property p_pres;
    rd_go && ra == ISS_A_BIN_CTL |=> rdata_q[31]
      && rdata_q[30:26] == 5'h0 && rdata_q[24:0] == 25'h0;
  endproperty
  a_pres: assert property (p_pres) else $error("bin rd"); // R2

  property p_off;
    !en_f_q && pix_valid |=> od_q == $past(pix_data);
  endproperty
  a_off: assert property (p_off) else $error("no ins"); // R3

  property p_nopad;
    win_rise && !line_q[15] && line_q == ht && !pad_present
      |=> !ok_f_q;
  endproperty
  a_nopad: assert property (p_nopad) else $error("pad"); // R8

  property p_ct;
    integ_start |=> ct_q == $past(ct_word);
  endproperty
  a_ct: assert property (p_ct) else $error("ct smp"); // R10

  property p_ct0;
    ins && bc_q == 6'h0 |=> od_q == $past(ct_q[7:0]);
  endproperty
  a_ct0: assert property (p_ct0) else $error("ct b0"); // R11

  property p_rng;
    off_q <= ISS_OFF_MAX && cyc_q <= ISS_CYC_MAX;
  endproperty
  a_rng: assert property (p_rng) else $error("ct rng"); // R12

  property p_fc;
    win_rise && !fc_rst |=> fc_q == $past(fc_q) + 32'h1;
  endproperty
  a_fc: assert property (p_fc) else $error("fc inc"); // R14

  property p_rst;
    fc_rst |=> fc_q == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("fc rst"); // R16

  property p_tc;
    trg_rise && !tc_rst |=> tc_q == $past(tc_q) + 32'h1;
  endproperty
  a_tc: assert property (p_tc) else $error("tc inc"); // R18

  property p_usr;
    ins && bc_q == 6'h2c |=> od_q == $past(rusr_q[7:0]);
  endproperty
  a_usr: assert property (p_usr) else $error("usr b0"); // R21

  c_ins: cover property (ins && bc_q == 6'h2f);
  c_neg: cover property (win_rise && line_q[15] && tgt_ok);
  c_frst: cover property (fc_rst);
  c_rd: cover property (rd_go && ra == ISS_A_FRM_VAL);
endmodule
`default_nettype wire

// File: tb/iss_frame_src.sv
/*
  Sensor side model: integration pulse, readout window and byte stream
  of 48-byte lines, with a one-cycle gap between lines, four cycles when slow is set.
  Assumes go is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module iss_frame_src (
  // Clock and control
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [15:0] n_lines,
  // Sensor side
  output logic             busy,
  output logic             window,
  output logic             integ,
  output logic             pv,
  output logic [7:0]       pd,
  output logic             ple
);
  // ========================================
  // Frame generator
  initial begin
    {busy, window, integ, pv, ple} = '0;
    pd = 8'h00;
    forever begin
      @(posedge clk);
      pd <= ~pd;
      if (go) begin
        busy <= 1'b1;
        integ <= 1'b1;
        @(posedge clk);
        integ <= 1'b0;
        repeat (3) @(posedge clk);
        window <= 1'b1;
        for (int l = 0; l < n_lines; l++) begin
          for (int b = 0; b < 48; b++) begin
            @(posedge clk);
            pv <= 1'b1;
            pd <= 8'ha5;
            ple <= (b == 47);
          end
          @(posedge clk);
          pv <= 1'b0;
          ple <= 1'b0;
          pd <= 8'h5a;
          if (slow) repeat (3) @(posedge clk);
        end
        window <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/iss_top_test.sv
/*
  Testbench of the image signature inserter: registers, binning,
  record placement, tallies and user words.
  Assumes the sensor model iss_frame_src.
*/
`timescale 1ns/1ns
`default_nettype none
module iss_top_test;
  import iss_pkg::*;
  // ========================================
  // Signals
  logic        clk, rstn, go, slow, busy, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        sensor_readout_window, integ_start, ext_trigger, seq_mode;
  logic        pad_present, pix_valid, pix_line_end, out_valid;
  logic        out_line_end, bin_valid, bin_x4, bin_out_valid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb, seq_index;
  logic [7:0]  pix_data, out_data;
  logic [15:0] image_line_total, n_lines, bin_sum, bin_out;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [7:0]  cap[$];
  logic        cle[$];
  int          failures, tests_run, cyc, t_int, nf, nt;

  iss_top dut (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sensor_readout_window, .integ_start, .ext_trigger, .seq_mode, .seq_index,
    .image_line_total, .pad_present, .pix_valid, .pix_data, .pix_line_end,
    .out_valid, .out_data, .out_line_end, .bin_valid, .bin_sum, .bin_x4,
    .bin_out_valid, .bin_out);
  iss_frame_src src (.clk, .go, .slow, .n_lines, .busy,
    .window(sensor_readout_window), .integ(integ_start), .pv(pix_valid),
    .pd(pix_data), .ple(pix_line_end));

  // ========================================
  // Clock, capture and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= rstn ? cyc + 1 : 0;
    if (integ_start === 1'b1) t_int <= cyc;
    if (out_valid === 1'b1) begin
      cap.push_back(out_data);
      cle.push_back(out_line_end);
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    test_done();
  end

  // ========================================
  // Shared tasks
  task test_done;
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [31:0] a, d, input logic [1:0] er);
    logic aw, wd;
    aw = 1'b1;
    wd = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (aw && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (wd && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        wd = 1'b0;
      end
    end while (aw || wd);
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", er, s_axi_bresp);
  endtask
  task rdc(input logic [31:0] a, e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  task trig(input int n);
    repeat (n) begin
      ext_trigger <= 1'b1;
      @(posedge clk);
      ext_trigger <= 1'b0;
      @(posedge clk);
    end
    nt += n;
  endtask
  task frame(input logic [15:0] h, input logic pad, input int ln, input logic [31:0] uw);
    logic [31:0] w;
    longint      tk;
    image_line_total <= h;
    pad_present <= pad;
    n_lines <= h + 16'(pad);
    cap.delete();
    cle.delete();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("bytes", 32'((h + pad) * 48), cap.size());
    for (int i = 0; i < cap.size(); i++) begin
      w = (i % 48 < 8) ? nf : (i % 48 < 12) ? nt : (i % 48 < 44) ? 0 : uw;
      chk("line_end", {31'h0, i % 48 == 47}, {31'h0, cle[i]});
      if (i / 48 != ln) chk("pixel", 32'h0a5, {24'h0, cap[i]});
      else if (i % 48 > 3) chk("record", (w >> (8 * (i % 4))) & 32'hff, {24'h0, cap[i]});
    end
    if (ln >= 0) begin
      w = {cap[ln*48+3], cap[ln*48+2], cap[ln*48+1], cap[ln*48]};
      tk = longint'(w[24:12]) * 3072 + longint'(w[11:0]) - longint'(t_int) * 24576 / 125000;
      chk("seconds", 0, {25'h0, w[31:25]});
      chk("cycle_time", 1, {31'h0, tk <= 2 && tk >= -2});
    end
    nf++;
  endtask

  // ========================================
  // Scenarios
  task t_regs;
    rdc(ISS_A_BIN_CTL, 32'h80000000, ISS_OKAY);
    wr(ISS_A_BIN_CTL, 32'hffffffff, ISS_OKAY);
    rdc(ISS_A_BIN_CTL, 32'h82000000, ISS_OKAY);
    wr(ISS_A_BIN_CTL, 32'h00000000, ISS_OKAY);
    rdc(ISS_A_BIN_CTL, 32'h80000000, ISS_OKAY);
    wr(ISS_A_SIG_CTL, 32'h7dff0000, ISS_OKAY);
    rdc(ISS_A_SIG_CTL, 32'h80000000, ISS_OKAY);
    rdc(ISS_A_FRM_CTL, 32'h80000000, ISS_OKAY);
    rdc(ISS_A_TRG_CTL, 32'h80000000, ISS_OKAY);
    wr(ISS_A_FRM_VAL, 32'h12345678, ISS_OKAY);
    rdc(ISS_A_FRM_VAL, 32'h0, ISS_OKAY);
    rdc(ISS_A_SIG_USR, 32'h0, ISS_OKAY);
    wr(32'hf1000638, 32'h1, ISS_SLVERR);
    rdc(32'hf1000638, 32'h0, ISS_SLVERR);
  endtask
  task t_bin;
    for (int k = 0; k < 4; k++) begin
      wr(ISS_A_BIN_CTL, k[1] ? 32'h02000000 : 32'h0, ISS_OKAY);
      bin_x4 <= k[0];
      bin_sum <= 16'hfff7;
      bin_valid <= 1'b1;
      @(posedge clk);
      bin_valid <= 1'b0;
      #1;
      chk("bin_valid", 1, {31'h0, bin_out_valid});
      chk("bin_out", k[1] ? 16'hfff7 >> (k[0] ? 2 : 1) : 16'hfff7, {16'h0, bin_out});
      @(posedge clk);
    end
  endtask
  task t_sig;
    wr(ISS_A_SIG_CTL, 32'h02000000, ISS_OKAY);
    wr(ISS_A_SIG_USR, 32'hdeadbeef, ISS_OKAY);
    trig(3);
    frame(16'd4, 1'b0, 0, 32'hdeadbeef);
    trig(2);
    frame(16'd4, 1'b0, 0, 32'hdeadbeef);
    rdc(ISS_A_FRM_VAL, nf, ISS_OKAY);
    rdc(ISS_A_TRG_VAL, nt, ISS_OKAY);
  endtask
  task t_rst;
    trig(1);
    wr(ISS_A_FRM_CTL, 32'h40000000, ISS_OKAY);
    wr(ISS_A_TRG_CTL, 32'h40000000, ISS_OKAY);
    nf = 0;
    nt = 0;
    rdc(ISS_A_FRM_VAL, 32'h0, ISS_OKAY);
    rdc(ISS_A_TRG_VAL, 32'h0, ISS_OKAY);
    rdc(ISS_A_FRM_CTL, 32'h80000000, ISS_OKAY);
    rdc(ISS_A_TRG_CTL, 32'h80000000, ISS_OKAY);
    frame(16'd4, 1'b0, 0, 32'hdeadbeef);
  endtask
  task t_pos;
    int pos[6];
    int exl[6];
    pos = '{1, -1, -4, 4, 4, -5};
    exl = '{1, 3, 0, 4, -1, -1};
    for (int k = 0; k < 6; k++) begin
      slow <= k[0];
      wr(ISS_A_SIG_CTL, {16'h8200, 16'(pos[k])}, ISS_OKAY);
      frame(16'd4, k == 3, exl[k], 32'hdeadbeef);
    end
    wr(ISS_A_SIG_CTL, 32'h0, ISS_OKAY);
    frame(16'd4, 1'b0, -1, 32'hdeadbeef);
  endtask
  task t_seq;
    wr(ISS_A_SIG_CTL, 32'h02000000, ISS_OKAY);
    seq_mode <= 1'b1;
    seq_index <= 4'h3;
    wr(ISS_A_SIG_USR, 32'h11223344, ISS_OKAY);
    seq_index <= 4'h5;
    wr(ISS_A_SIG_USR, 32'h55667788, ISS_OKAY);
    rdc(ISS_A_SIG_USR, 32'h55667788, ISS_OKAY);
    seq_index <= 4'h3;
    rdc(ISS_A_SIG_USR, 32'h11223344, ISS_OKAY);
    frame(16'd4, 1'b0, 0, 32'h11223344);
  endtask

  // ========================================
  // Main sequence
  initial begin
    {rstn, go, slow, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {ext_trigger, seq_mode, pad_present, bin_valid, bin_x4} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_wstrb = 4'hf;
    seq_index = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {image_line_total, n_lines, bin_sum} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_bin();
    t_sig();
    t_rst();
    t_pos();
    t_seq();
    test_done();
  end
endmodule
`default_nettype wire
